// >>> chop_source.sv
/*
  chop clock model of the controlling core's timer.
  assumes clk_in and reset_in of the bench; run_in gates the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module chop_source #(
  parameter int HALF = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic run_in,
  output logic chop_out
);
  int cnt;

  // --------------------------------
  // clock stands low outside runs
  // --------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in || !run_in)
    begin
      cnt <= 0;
      chop_out <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      chop_out <= !chop_out;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // chop_source

`default_nettype wire

// >>> power_stage_control_status.sv
/*
  apb register bank and protection logic for four half-bridges, the
  switched supply and lin transmitter controls.
  assumes analog comparators and the chop input are asynchronous pins;
  the apb master sits on clk_in.
*/
// What this block does
// - offset chop: bridges 1,2 rise, 3,4 fall
// - sense gain bit selects 500 mA range
// - recirculation output follows any bridge detection
// - overtemp sets flag; enabled reset kills bridges and supply
// - high side overcurrent: all highs and lows off, flag
// - low side overcurrent: all lows and highs off, flag
// - write one clears bridge overcurrent flag
// - voltage flags force bridges off until cleared
// - voltage clear ignored while condition present
// - bridge control register holds chop, gain, limit
// - limit codes below 011 mean no limit
// - supply on needs enable and on bit
// - supply overtemp only with high temp reset
// - supply overcurrent: off, flag, write one clears
// - power stage enable gates bridges, lin, supply
// - two-bit lin slew select encoding
// - stop request write-only, cleared by interrupt
// - lin current limit flag read-only mirror
// - status voltage, temp bits mirror flag register
// - status register bit positions fixed
// - limited low side resumes on chop rise, on fall for 3,4 with offset chop
// - high side wins over low side
`timescale 1ns/1ps
`default_nettype none
`include "power_stage_defs.svh"

module power_stage_control_status (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic chop_frequency_input_in,
  input wire logic [3:0] recirculation_in,
  input wire logic [3:0] high_overcurrent_in,
  input wire logic [3:0] low_overcurrent_in,
  input wire logic [3:0] low_current_limit_in,
  input wire logic undervoltage_in,
  input wire logic overvoltage_in,
  input wire logic overtemp_warning_in,
  input wire logic overtemp_limit_in,
  input wire logic supply_overcurrent_in,
  input wire logic lin_current_limit_in,
  input wire logic cpu_interrupt_in,
  output logic [3:0] high_side_on_out,
  output logic [3:0] low_side_on_out,
  output logic recirculation_detect_output_out,
  output logic sense_gain_select_out,
  output logic [2:0] current_limit_select_out,
  output logic limit_active_out,
  output logic switched_supply_output_out,
  output logic lin_transmit_enable_out,
  output logic [1:0] lin_slew_select_out,
  output logic stop_request_out,
  output logic overtemp_reset_out
);

  // ------------------------------------------------------------
  // pin synchronisers, three stages, change once stages 2 and 3 agree
  // ------------------------------------------------------------
  localparam int N_PINS = 23;
  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_s1;
  logic [N_PINS-1:0] pin_s2;
  logic [N_PINS-1:0] pin_s3;
  logic [N_PINS-1:0] pin;
  logic [N_PINS-1:0] next_pin;

  assign pin_raw = {recirculation_in, high_overcurrent_in, low_overcurrent_in, low_current_limit_in,
                    undervoltage_in, overvoltage_in, overtemp_warning_in, overtemp_limit_in,
                    supply_overcurrent_in, lin_current_limit_in, chop_frequency_input_in};

  always_comb
  begin
    for (int i = 0; i < N_PINS; i++)
    begin
      next_pin[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin[i];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin <= '0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin <= next_pin;
    end
  end

  logic [3:0] recirc;
  logic [3:0] high_oc;
  logic [3:0] low_oc;
  logic [3:0] low_lim;
  logic uv;
  logic ov;
  logic ot_warn;
  logic ot_limit;
  logic supply_oc;
  logic lin_cl;
  logic chop;
  assign {recirc, high_oc, low_oc, low_lim, uv, ov, ot_warn, ot_limit, supply_oc, lin_cl, chop} = pin;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  power_stage_pkg::state_t state;
  power_stage_pkg::state_t next_state;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] wbyte;
  logic chop_rise;
  logic chop_fall;
  logic [7:0] status_view;
  logic bridges_allowed;

  assign wr_en = psel_in && penable_in && pwrite_in && pstrb_in[0];
  assign rd_en = psel_in && penable_in && !pwrite_in;
  assign wbyte = pwdata_in[7:0];
  assign chop_rise = chop && !state.chop_level;
  assign chop_fall = !chop && state.chop_level;

  always_comb
  begin
    case (paddr_in)
      `BRIDGE_OUTPUT_REG_ADDR,
      `BRIDGE_CONTROL_REG_ADDR,
      `SYSTEM_CONTROL_REG_ADDR,
      `POWER_OUTPUT_REG_ADDR,
      `SYSTEM_STATUS_REG_ADDR,
      `INTERRUPT_FLAG_REG_ADDR,
      `PROTECT_CONTROL_REG_ADDR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // status byte, unused bits zero
  always_comb
  begin
    status_view = 8'h00;
    status_view[`ST_LIN_CL_BIT] = lin_cl;
    status_view[`ST_SUPPLY_OC_BIT] = state.switched_supply_overcurrent_flag;
    status_view[`ST_UNDERVOLT_BIT] = state.undervoltage_flag;
    status_view[`ST_OVERVOLT_BIT] = state.overvoltage_flag;
    status_view[`ST_BRIDGE_OC_BIT] = state.bridge_overcurrent_flag;
    status_view[`ST_OVERTEMP_BIT] = state.overtemp_flag;
  end

  always_comb
  begin
    next_state = state;
    next_state.chop_level = chop;
    next_state.pslverr = 1'b0;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    if (wr_en)
    begin
      case (paddr_in)
        `BRIDGE_OUTPUT_REG_ADDR: next_state.bridge_output_reg = wbyte;
        `BRIDGE_CONTROL_REG_ADDR:
        begin
          next_state.offset_chop_enable = wbyte[`CTL_OFFSET_CHOP_BIT];
          next_state.sense_gain_select = wbyte[`CTL_SENSE_GAIN_BIT];
          next_state.current_limit_select = wbyte[`CTL_LIMIT_LSB +: 3];
        end
        `SYSTEM_CONTROL_REG_ADDR:
        begin
          next_state.power_stage_enable = wbyte[`SYS_POWER_STAGE_BIT];
          next_state.lin_slew_select = wbyte[`SYS_SLEW_LSB +: 2];
          // stop request, only set by a one
          if (wbyte[`SYS_STOP_BIT])
          begin
            next_state.stop_request = 1'b1;
          end
        end
        `POWER_OUTPUT_REG_ADDR: next_state.switched_supply_on = wbyte[`POWER_OUTPUT_REG_SUPPLY_ON_BIT];
        `PROTECT_CONTROL_REG_ADDR: next_state.ht_reset_enable = wbyte[`PROT_HT_RESET_EN_BIT];
        `SYSTEM_STATUS_REG_ADDR:
        begin
          if (wbyte[`ST_BRIDGE_OC_BIT])
          begin
            next_state.bridge_overcurrent_flag = 1'b0;
          end
          if (wbyte[`ST_SUPPLY_OC_BIT])
          begin
            next_state.switched_supply_overcurrent_flag = 1'b0;
          end
        end
        `INTERRUPT_FLAG_REG_ADDR:
        begin
          if (wbyte[`ST_UNDERVOLT_BIT])
          begin
            next_state.undervoltage_flag = 1'b0;
          end
          if (wbyte[`ST_OVERVOLT_BIT])
          begin
            next_state.overvoltage_flag = 1'b0;
          end
          if (wbyte[`ST_OVERTEMP_BIT])
          begin
            next_state.overtemp_flag = 1'b0;
          end
        end
        default: next_state.pslverr = 1'b1;
      endcase
    end
    else if (rd_en && !addr_ok)
    begin
      next_state.pslverr = 1'b1;
    end

    // ------------------------------------------------------------
    // hardware events, set wins over clear; interrupt clear wins over stop write
    // ------------------------------------------------------------
    // clear ignored while condition present
    if (uv)
    begin
      next_state.undervoltage_flag = 1'b1;
    end
    if (ov)
    begin
      next_state.overvoltage_flag = 1'b1;
    end
    if (ot_warn)
    begin
      next_state.overtemp_flag = 1'b1;
    end
    if (|high_oc || |low_oc)
    begin
      next_state.bridge_overcurrent_flag = 1'b1;
    end
    if (supply_oc)
    begin
      next_state.switched_supply_overcurrent_flag = 1'b1;
    end
    if (cpu_interrupt_in)
    begin
      next_state.stop_request = 1'b0;
    end

    // ------------------------------------------------------------
    // current limit chopping
    // ------------------------------------------------------------
    for (int i = 0; i < 4; i++)
    begin
      // bridges 1,2 rise, 3,4 fall when offset chop on
      if ((i < 2 || !state.offset_chop_enable) ? chop_rise : chop_fall)
      begin
        // limited low side resumes on chop edge
        next_state.low_limited[i] = 1'b0;
      end
      // codes 000 to 010 disable limiting
      if (low_lim[i] && state.current_limit_select >= 3'h3)
      begin
        next_state.low_limited[i] = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    next_state.prdata = 8'h00;
    if (rd_en)
    begin
      case (paddr_in)
        `BRIDGE_OUTPUT_REG_ADDR: next_state.prdata = state.bridge_output_reg;
        `BRIDGE_CONTROL_REG_ADDR: next_state.prdata = {3'h0, state.offset_chop_enable,
                                                       state.sense_gain_select, state.current_limit_select};
        `SYSTEM_CONTROL_REG_ADDR: next_state.prdata = {state.power_stage_enable, state.lin_slew_select, 5'h00};
        `POWER_OUTPUT_REG_ADDR: next_state.prdata = {6'h00, state.switched_supply_on, 1'b0};
        `SYSTEM_STATUS_REG_ADDR: next_state.prdata = status_view;
        `INTERRUPT_FLAG_REG_ADDR: next_state.prdata = {4'h0, state.undervoltage_flag,
                                                       state.overvoltage_flag, 1'b0, state.overtemp_flag};
        `PROTECT_CONTROL_REG_ADDR: next_state.prdata = {7'h00, state.ht_reset_enable};
        default: next_state.prdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // apb answer, one wait state: data registered in access cycle
  // ------------------------------------------------------------
  logic access_seen;
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      access_seen <= 1'b0;
    end
    else
    begin
      access_seen <= psel_in && penable_in && !access_seen;
    end
  end

  assign pready_out = access_seen;
  assign prdata_out = {24'h000000, state.prdata};
  assign pslverr_out = access_seen && state.pslverr;

  // ------------------------------------------------------------
  // output drive
  // ------------------------------------------------------------
  logic overtemp_kill;
  logic [3:0] high_req;
  logic [3:0] low_req;

  assign overtemp_kill = state.ht_reset_enable && ot_limit;
  // voltage flags and enable gate bridges
  assign bridges_allowed = state.power_stage_enable && !state.undervoltage_flag && !state.overvoltage_flag
                           && !overtemp_kill;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      high_req[i] = state.bridge_output_reg[2 * i + 1];
      low_req[i] = state.bridge_output_reg[2 * i] && !high_req[i];
    end
  end

  // high or low overcurrent latches all highs off
  assign high_side_on_out = bridges_allowed && !state.bridge_overcurrent_flag ? high_req : 4'h0;
  // high or low overcurrent latches all lows off
  assign low_side_on_out = bridges_allowed && !state.bridge_overcurrent_flag ? (low_req & ~state.low_limited) : 4'h0;
  assign recirculation_detect_output_out = |recirc;
  assign sense_gain_select_out = state.sense_gain_select;
  assign current_limit_select_out = state.current_limit_select;
  assign limit_active_out = state.current_limit_select >= 3'h3;
  assign switched_supply_output_out = state.power_stage_enable && state.switched_supply_on
                                      && !state.switched_supply_overcurrent_flag && !overtemp_kill;
  assign lin_transmit_enable_out = state.power_stage_enable;
  assign lin_slew_select_out = state.lin_slew_select;
  assign stop_request_out = state.stop_request;
  assign overtemp_reset_out = overtemp_kill;

endmodule // power_stage_control_status

`default_nettype wire

// >>> power_stage_control_status_checker.sv
/*
  port checks of the power stage bank.
  assumes one clock, clk_in, with synchronous reset_in.
*/
`timescale 1ns/1ps
`default_nettype none

module power_stage_control_status_checker (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [3:0] recirculation_in,
  input wire logic [3:0] high_overcurrent_in,
  input wire logic [3:0] low_overcurrent_in,
  input wire logic undervoltage_in,
  input wire logic overvoltage_in,
  input wire logic supply_overcurrent_in,
  input wire logic cpu_interrupt_in,
  input wire logic [3:0] high_side_on_out,
  input wire logic [3:0] low_side_on_out,
  input wire logic recirculation_detect_output_out,
  input wire logic [2:0] current_limit_select_out,
  input wire logic limit_active_out,
  input wire logic switched_supply_output_out,
  input wire logic stop_request_out,
  input wire logic overtemp_reset_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  // --------------------------------
  // assertions
  // --------------------------------
  a_side_exclusive: assert property ((high_side_on_out & low_side_on_out) == 4'h0)
    else $error("high and low side on together");
  a_limit_decode: assert property (limit_active_out ==
    (current_limit_select_out[2] || &current_limit_select_out[1:0]))
    else $error("limit active wrong");
  a_recirc_high: assert property ((|recirculation_in) [*8] |-> recirculation_detect_output_out)
    else $error("recirculation output low");
  a_undervolt_off: assert property (undervoltage_in [*8] |-> {high_side_on_out, low_side_on_out} == 8'h00)
    else $error("bridges on in undervoltage");
  a_overvolt_off: assert property (overvoltage_in [*8] |-> {high_side_on_out, low_side_on_out} == 8'h00)
    else $error("bridges on in overvoltage");
  a_high_oc_off: assert property ((|high_overcurrent_in) [*8] |-> high_side_on_out == 4'h0)
    else $error("high side on in overcurrent");
  a_low_oc_off: assert property ((|low_overcurrent_in) [*8] |-> low_side_on_out == 4'h0)
    else $error("low side on in overcurrent");
  a_supply_oc_off: assert property (supply_overcurrent_in [*8] |-> !switched_supply_output_out)
    else $error("supply on in overcurrent");
  a_temp_reset_off: assert property (overtemp_reset_out |-> !switched_supply_output_out
    && {high_side_on_out, low_side_on_out} == 8'h00)
    else $error("outputs on in overtemp reset");
  a_stop_clear: assert property (cpu_interrupt_in |=> !stop_request_out)
    else $error("stop request kept");
  a_apb_wait: assert property ($rose(penable_in) && psel_in |=> pready_out)
    else $error("ready late");

  cover property (pslverr_out);
  cover property (limit_active_out);
  cover property (overtemp_reset_out);
endmodule // power_stage_control_status_checker

bind power_stage_control_status power_stage_control_status_checker checker_i (
  .clk_in, .reset_in, .psel_in, .penable_in, .pready_out, .pslverr_out, .recirculation_in,
  .high_overcurrent_in, .low_overcurrent_in, .undervoltage_in, .overvoltage_in, .supply_overcurrent_in,
  .cpu_interrupt_in, .high_side_on_out, .low_side_on_out, .recirculation_detect_output_out,
  .current_limit_select_out, .limit_active_out, .switched_supply_output_out, .stop_request_out,
  .overtemp_reset_out
);

`default_nettype wire

// >>> power_stage_control_status_tb.sv
/*
  testbench of the power stage bank.
  assumes the chop source model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "power_stage_defs.svh"

module power_stage_control_status_tb;
  localparam logic [11:0] ad_out = `BRIDGE_OUTPUT_REG_ADDR;
  localparam logic [11:0] ad_ctl = `BRIDGE_CONTROL_REG_ADDR;
  localparam logic [11:0] ad_sys = `SYSTEM_CONTROL_REG_ADDR;
  localparam logic [11:0] ad_pwr = `POWER_OUTPUT_REG_ADDR;
  localparam logic [11:0] ad_st = `SYSTEM_STATUS_REG_ADDR;
  localparam logic [11:0] ad_irq = `INTERRUPT_FLAG_REG_ADDR;
  localparam logic [11:0] ad_prot = `PROTECT_CONTROL_REG_ADDR;
  typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] r; logic [7:0] o;} row_t;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic run = 1'b0;
  logic chop;
  logic [3:0] recirc = 4'h0;
  logic [7:0] oc = 8'h00;
  logic [3:0] lim = 4'h0;
  logic [1:0] volt = 2'h0;
  logic [3:0] strb = 4'hf;
  logic sup_oc = 1'b0, lin_cl = 1'b0, ot_warn = 1'b0, ot_lim = 1'b0, cpu_int = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, recirculation_detect_output_out, sense_gain_select_out, limit_active_out;
  logic switched_supply_output_out, lin_transmit_enable_out, stop_request_out, overtemp_reset_out;
  logic [3:0] high_side_on_out, low_side_on_out;
  logic [2:0] current_limit_select_out;
  logic [1:0] lin_slew_select_out;
  int err_total = 0;
  int checked = 0;
  logic [11:0] regs [5] = '{ad_out, ad_ctl, ad_sys, ad_pwr, ad_st};
  row_t rows [14] = '{
    '{ad_sys, 8'h80, 8'h80, 8'h01}, '{ad_sys, 8'ha0, 8'ha0, 8'h03}, '{ad_sys, 8'hc0, 8'hc0, 8'h05},
    '{ad_sys, 8'he0, 8'he0, 8'h07}, '{ad_pwr, 8'h02, 8'h02, 8'h01}, '{ad_pwr, 8'hff, 8'h02, 8'h01},
    '{ad_ctl, 8'h1b, 8'h1b, 8'h17}, '{ad_ctl, 8'h07, 8'h07, 8'h0f}, '{ad_ctl, 8'h04, 8'h04, 8'h09},
    '{ad_ctl, 8'he2, 8'h02, 8'h04}, '{ad_out, 8'h55, 8'h55, 8'h0f}, '{ad_out, 8'haa, 8'haa, 8'hf0},
    '{ad_out, 8'hff, 8'hff, 8'hf0}, '{ad_out, 8'h36, 8'h36, 8'h52}};

  power_stage_control_status dut (
    .clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in(strb),
    .prdata_out, .pready_out, .pslverr_out, .chop_frequency_input_in(chop), .recirculation_in(recirc),
    .high_overcurrent_in(oc[7:4]), .low_overcurrent_in(oc[3:0]), .low_current_limit_in(lim),
    .undervoltage_in(volt[1]), .overvoltage_in(volt[0]), .overtemp_warning_in(ot_warn),
    .overtemp_limit_in(ot_lim), .supply_overcurrent_in(sup_oc), .lin_current_limit_in(lin_cl),
    .cpu_interrupt_in(cpu_int), .high_side_on_out, .low_side_on_out, .recirculation_detect_output_out,
    .sense_gain_select_out, .current_limit_select_out, .limit_active_out, .switched_supply_output_out,
    .lin_transmit_enable_out, .lin_slew_select_out, .stop_request_out, .overtemp_reset_out
  );
  chop_source #(.HALF(16)) model (.clk_in, .reset_in, .run_in(run), .chop_out(chop));

  always #5 clk_in = ~clk_in;

  // --------------------------------
  // tasks
  // --------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic hang;
    err_total++;
    $display("[FAIL] t=%0t wait ran out", $time);
    conclude();
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 20);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20) hang();
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, 32'(x));
  endtask

  task automatic settle;
    repeat (10) @(posedge clk_in);
  endtask

  task automatic wait_chop(input logic v);
    int n;
    n = 0;
    while (chop !== v && n < 100)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 100) hang();
  endtask

  task automatic do_reset;
    reset_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
  endtask

  function automatic logic [7:0] watch(input logic [11:0] a);
    case (a)
      ad_out: return {high_side_on_out, low_side_on_out};
      ad_ctl: return {3'h0, sense_gain_select_out, current_limit_select_out, limit_active_out};
      ad_sys: return {5'h0, lin_slew_select_out, lin_transmit_enable_out};
      default: return {7'h0, switched_supply_output_out};
    endcase
  endfunction

  // --------------------------------
  // sequence
  // --------------------------------
  initial
  begin
    logic [31:0] r;
    logic e;
    do_reset();
    foreach (regs[i]) rd(regs[i], 8'h00);
    apb(1'b0, 12'h100, 8'h00, r, e);
    chk(32'(e), 32'h1);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
      chk(32'(watch(rows[i].a)), 32'(rows[i].o));
    end
    strb <= 4'h0;
    wr(ad_pwr, 8'h00);
    strb <= 4'hf;
    rd(ad_pwr, 8'h02);
    $display("test table done");
    wr(ad_sys, 8'he1);
    chk(32'(stop_request_out), 32'h1);
    rd(ad_sys, 8'he0);
    cpu_int <= 1'b1;
    @(posedge clk_in);
    cpu_int <= 1'b0;
    @(posedge clk_in);
    chk(32'(stop_request_out), 32'h0);
    recirc <= 4'h4;
    settle();
    chk(32'(recirculation_detect_output_out), 32'h1);
    recirc <= 4'h0;
    settle();
    chk(32'(recirculation_detect_output_out), 32'h0);
    $display("test stop and recirculation done");
    wr(ad_out, 8'h55);
    for (int k = 0; k < 2; k++)
    begin
      volt <= 2'h1 << k;
      settle();
      chk(32'({high_side_on_out, low_side_on_out}), 32'h0);
      rd(ad_st, 8'h04 << k);
      wr(ad_irq, 8'h04 << k);
      rd(ad_irq, 8'h04 << k);
      volt <= 2'h0;
      settle();
      wr(ad_irq, 8'h04 << k);
      rd(ad_st, 8'h00);
      chk(32'({high_side_on_out, low_side_on_out}), 32'h0f);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(ad_out, k ? 8'haa : 8'h55);
      oc <= k ? 8'h20 : 8'h02;
      settle();
      chk(32'({high_side_on_out, low_side_on_out}), 32'h0);
      oc <= 8'h00;
      settle();
      wr(ad_st, 8'h00);
      rd(ad_st, 8'h02);
      wr(ad_st, 8'h02);
      rd(ad_st, 8'h00);
      chk(32'({high_side_on_out, low_side_on_out}), k ? 32'hf0 : 32'h0f);
    end
    $display("test bridge protection done");
    chk(32'(switched_supply_output_out), 32'h1);
    sup_oc <= 1'b1;
    settle();
    chk(32'(switched_supply_output_out), 32'h0);
    rd(ad_st, 8'h20);
    sup_oc <= 1'b0;
    settle();
    wr(ad_st, 8'h20);
    rd(ad_st, 8'h00);
    chk(32'(switched_supply_output_out), 32'h1);
    lin_cl <= 1'b1;
    settle();
    rd(ad_st, 8'h40);
    wr(ad_sys, 8'h00);
    lin_cl <= 1'b0;
    chk(32'({high_side_on_out, low_side_on_out}), 32'h0);
    chk(32'({switched_supply_output_out, lin_transmit_enable_out}), 32'h0);
    wr(ad_sys, 8'h80);
    $display("test supply and lin done");
    wr(ad_out, 8'h55);
    wr(ad_ctl, 8'h13);
    lim <= 4'hf;
    settle();
    lim <= 4'h0;
    settle();
    chk(32'(low_side_on_out), 32'h0);
    run <= 1'b1;
    wait_chop(1'b1);
    settle();
    chk(32'(low_side_on_out), 32'h3);
    wait_chop(1'b0);
    settle();
    chk(32'(low_side_on_out), 32'hf);
    run <= 1'b0;
    wr(ad_ctl, 8'h03);
    lim <= 4'hf;
    settle();
    lim <= 4'h0;
    run <= 1'b1;
    wait_chop(1'b1);
    settle();
    chk(32'(low_side_on_out), 32'hf);
    run <= 1'b0;
    $display("test chopping done");
    ot_warn <= 1'b1;
    settle();
    rd(ad_st, 8'h01);
    ot_warn <= 1'b0;
    settle();
    wr(ad_irq, 8'h01);
    rd(ad_st, 8'h00);
    ot_lim <= 1'b1;
    settle();
    chk(32'({overtemp_reset_out, switched_supply_output_out}), 32'h1);
    wr(ad_prot, 8'h01);
    chk(32'({overtemp_reset_out, switched_supply_output_out, high_side_on_out, low_side_on_out}), 32'h200);
    ot_lim <= 1'b0;
    do_reset();
    rd(ad_st, 8'h00);
    chk(32'({overtemp_reset_out, high_side_on_out, low_side_on_out}), 32'h0);
    $display("test overtemp done");
    conclude();
  end
endmodule // power_stage_control_status_tb

`default_nettype wire

// >>> power_stage_defs.svh
/*
  register offsets, field positions and reset values of the power stage
  control and status bank. assumes byte addresses on a 32-bit apb bus.
*/
`ifndef POWER_STAGE_DEFS_SVH
`define POWER_STAGE_DEFS_SVH

// ------------------------------------------------------------
// offsets
// ------------------------------------------------------------
`define BRIDGE_OUTPUT_REG_ADDR 12'h004
`define BRIDGE_CONTROL_REG_ADDR 12'h008
`define SYSTEM_CONTROL_REG_ADDR 12'h00c
`define POWER_OUTPUT_REG_ADDR 12'h02c
`define SYSTEM_STATUS_REG_ADDR 12'h030
`define INTERRUPT_FLAG_REG_ADDR 12'h040
`define PROTECT_CONTROL_REG_ADDR 12'h044

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTL_OFFSET_CHOP_BIT 4
`define CTL_SENSE_GAIN_BIT 3
`define CTL_LIMIT_LSB 0
`define SYS_POWER_STAGE_BIT 7
`define SYS_SLEW_LSB 5
`define SYS_STOP_BIT 0
`define POWER_OUTPUT_REG_SUPPLY_ON_BIT 1
`define ST_LIN_CL_BIT 6
`define ST_SUPPLY_OC_BIT 5
`define ST_UNDERVOLT_BIT 3
`define ST_OVERVOLT_BIT 2
`define ST_BRIDGE_OC_BIT 1
`define ST_OVERTEMP_BIT 0
`define PROT_HT_RESET_EN_BIT 0

// ------------------------------------------------------------
// reset values and masks
// ------------------------------------------------------------
`define REG_RESET 8'h00
`define CTL_WRITE_MASK 8'h1f
`define SYS_WRITE_MASK 8'he0
`define POWER_OUTPUT_REG_WRITE_MASK 8'h02

`endif

// >>> power_stage_pkg.sv
/*
  types of the power stage control and status bank.
  assumes power_stage_defs.svh for the numbers.
*/
package power_stage_pkg;

  typedef enum logic [1:0] {
    slew_initial_20k = 2'h0,
    slew_slow_10k = 2'h1,
    slew_fast_8x = 2'h2,
    slew_fast_4x = 2'h3
  } lin_slew_t;

  typedef struct packed {
    logic [7:0] bridge_output_reg;
    logic offset_chop_enable;
    logic sense_gain_select;
    logic [2:0] current_limit_select;
    logic power_stage_enable;
    logic [1:0] lin_slew_select;
    logic stop_request;
    logic switched_supply_on;
    logic ht_reset_enable;
    logic undervoltage_flag;
    logic overvoltage_flag;
    logic overtemp_flag;
    logic bridge_overcurrent_flag;
    logic switched_supply_overcurrent_flag;
    logic [3:0] low_limited;
    logic chop_level;
    logic [7:0] prdata;
    logic pslverr;
  } state_t;

endpackage
